// ==== core/charger_ctrl_defs.svh ====
`ifndef CHARGER_CTRL_DEFS_SVH
`define CHARGER_CTRL_DEFS_SVH

// Clock rate in kHz and pulse/press times
`define CLK_KHZ 40000
`define ALERT_PULSE_US 256
`define ALERT_PULSE_CYC ((`ALERT_PULSE_US * `CLK_KHZ) / 1000)
`define BLINK_HALF_MS 500
`define BLINK_HALF_CYC ((`BLINK_HALF_MS * `CLK_KHZ))
`define STORAGE_EXIT_PRESS_MS 1000
`define RESET_PRESS_MS 10000
`define SWITCH_OFF_MS 300
`define DEBOUNCE_CYC 16'h0100

// APB register byte offsets
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_EVENT 12'h008
`define REG_EVENT_CLEAR 12'h00c
`define REG_EVENT_ENABLE 12'h010

// Control register fields
`define CTL_BOOST_ALLOW 0
`define CTL_CHARGE_ALLOW 1
`define CTL_CAP_PIN_USE 2
`define CTL_STORAGE_ENTER 3
`define CTL_FAULT 4
`define CTL_CAP_LSB 8
`define CTL_RESET 32'h0000_0002

// Event bits
`define EV_STATUS_CHANGE 0
`define EV_FAULT 1
`define EV_BUTTON 2
`define EV_WIDTH 3

`endif

// ==== core/charger_ctrl_pkg.sv ====
package charger_ctrl_pkg;

  // Width of current cap code
  typedef logic [7:0] cap_code_t;

  // Battery switch sequencer states
  typedef enum logic [3:0] {
    SW_ON = 4'b0001,
    SW_STORAGE = 4'b0010,
    SW_RESET_OFF = 4'b0100,
    SW_WAIT_RELEASE = 4'b1000
  } switch_state_t;

  // Status bundle that the block reports
  typedef struct packed {
    logic boostActive;
    logic chargeActive;
    logic switchOn;
    logic storage;
    logic thermOk;
  } status_t;

endpackage : charger_ctrl_pkg

// ==== core/charger_control_pin_logic.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "charger_ctrl_defs.svh"

module charger_control_pin_logic #(
  parameter int unsigned STORAGE_EXIT_CYC = `STORAGE_EXIT_PRESS_MS * `CLK_KHZ,
  parameter int unsigned RESET_PRESS_CYC = `RESET_PRESS_MS * `CLK_KHZ,
  parameter int unsigned SWITCH_OFF_CYC = `SWITCH_OFF_MS * `CLK_KHZ,
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boostRequestPin,
  input wire logic chargeEnablePin_n,
  input wire logic inputSupplyPresent,
  input wire logic [7:0] currentCapPin,
  input wire logic thermistorWindowOk,
  input wire logic wakeButton_n,
  output logic alertOut,
  output logic alertOe,
  output logic chargeIndOut,
  output logic chargeIndOe,
  output logic boostEnable,
  output logic chargeEnable,
  output logic [7:0] effectiveCurrentCap,
  output logic batterySwitchOn,
  output logic irq
);

  // Register and control state
  logic [31:0] control_q, control_d;
  logic [`EV_WIDTH-1:0] event_q, event_d;
  logic [`EV_WIDTH-1:0] eventEn_q, eventEn_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  // Output and datapath state
  logic boost_q, boost_d;
  logic charge_q, charge_d;
  charger_ctrl_pkg::cap_code_t cap_q, cap_d;
  charger_ctrl_pkg::status_t status_q, status_d;
  logic [31:0] alertCnt_q, alertCnt_d;
  logic alertLow_q, alertLow_d;
  logic [31:0] blinkCnt_q, blinkCnt_d;
  logic blink_q, blink_d;
  logic indLow_q, indLow_d;

  // Button and switch state
  logic [1:0] btnSync_q, btnSync_d;
  logic btnDeb_q, btnDeb_d;
  logic [15:0] debCnt_q, debCnt_d;
  logic [31:0] pressCnt_q, pressCnt_d;
  logic [31:0] offCnt_q, offCnt_d;
  charger_ctrl_pkg::switch_state_t sw_q, sw_d;
  logic swOn_q, swOn_d;

  // Combinational strobes and decoded fields
  logic apbAccess;
  logic apbWrite;
  logic faultNow;
  logic eventStatus;
  logic eventFault;
  logic eventButton;
  logic [`EV_WIDTH-1:0] eventSet;
  logic [7:0] regCap;
  // Fault history for edge reporting and the event clear strobe
  logic faultSeen_q, faultSeen_d;
  logic eventClear;

  assign apbAccess = psel && penable && !pready_q;
  assign apbWrite = apbAccess && pwrite;
  assign regCap = control_q[`CTL_CAP_LSB +: 8];
  assign faultNow = control_q[`CTL_FAULT] || !thermistorWindowOk;

  // Single-cycle APB answer; unmapped offsets return slave error
  // Writes land at the access edge; the registered pready gives one wait state
  always_comb begin
    control_d = control_q;
    eventEn_d = eventEn_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (apbAccess) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (paddr)
        `REG_CONTROL: begin
          prdata_d = control_q;
          if (pwrite) begin
            control_d = pwdata;
          end
        end
        `REG_STATUS: prdata_d = {27'h000_0000, status_q};
        `REG_EVENT: prdata_d = {29'h0000_0000, event_q};
        `REG_EVENT_CLEAR: prdata_d = 32'h0000_0000;
        `REG_EVENT_ENABLE: begin
          prdata_d = {29'h0000_0000, eventEn_q};
          if (pwrite) begin
            eventEn_d = pwdata[`EV_WIDTH-1:0];
          end
        end
        default: pslverr_d = 1'b1;
      endcase
    end
    // Storage request is a one-shot command bit
    if (control_q[`CTL_STORAGE_ENTER]) begin
      control_d[`CTL_STORAGE_ENTER] = 1'b0;
    end
  end

  // Raw event strobes; a fault is reported once, when it first appears
  always_comb begin
    eventStatus = (status_q != status_d);
    eventFault = faultNow && !faultSeen_q;
    eventButton = (sw_q != sw_d);
    eventSet = {eventButton, eventFault, eventStatus};
    faultSeen_d = faultNow;
    irq_d = |(event_d & eventEn_q);
  end

  // Write-one clear strobe for the sticky event bits
  assign eventClear = apbWrite && (paddr == `REG_EVENT_CLEAR);

  // Sticky event bits, one slice per event; the set wins over a clear
  // in the same cycle so that an event is never lost to a racing clear
  for (genvar b = 0; b < `EV_WIDTH; b++) begin : gen_event
    assign event_d[b] = eventSet[b] || (event_q[b] && !(eventClear && pwdata[b]));
  end

  // Gating of boost, charging and current cap
  // All three follow their inputs within one cycle; nothing here is latched
  always_comb begin
    boost_d = control_q[`CTL_BOOST_ALLOW] && boostRequestPin && !inputSupplyPresent;
    charge_d = control_q[`CTL_CHARGE_ALLOW] && !chargeEnablePin_n
               && thermistorWindowOk && swOn_q;
    if (control_q[`CTL_CAP_PIN_USE]) begin
      cap_d = (currentCapPin < regCap) ? currentCapPin : regCap;
    end else begin
      cap_d = regCap;
    end
    status_d.boostActive = boost_d;
    status_d.chargeActive = charge_d;
    status_d.switchOn = swOn_q;
    status_d.storage = (sw_q == charger_ctrl_pkg::SW_STORAGE);
    status_d.thermOk = thermistorWindowOk;
  end

  // Alert pulse, retriggered by any status change or new fault
  // A new event restarts the full pulse, so the host never sees a short one
  always_comb begin
    alertCnt_d = alertCnt_q;
    alertLow_d = alertLow_q;
    if (eventStatus || eventFault) begin
      alertCnt_d = 32'(`ALERT_PULSE_CYC - 1);
      alertLow_d = 1'b1;
    end else if (alertCnt_q != 32'h0) begin
      alertCnt_d = alertCnt_q - 32'h1;
    end else begin
      alertLow_d = 1'b0;
    end
  end

  // Charge indicator with 1 Hz blink on fault
  // The counter idles at zero, so the first blink phase after a fault is full length
  always_comb begin
    blinkCnt_d = blinkCnt_q;
    blink_d = blink_q;
    if (!faultNow) begin
      blinkCnt_d = 32'h0;
      blink_d = 1'b0;
    end else if (blinkCnt_q >= BLINK_HALF_CYC - 1) begin
      blinkCnt_d = 32'h0;
      blink_d = !blink_q;
    end else begin
      blinkCnt_d = blinkCnt_q + 32'h1;
    end
    indLow_d = faultNow ? blink_d : charge_d;
  end

  // Button synchroniser and debounce; the first stage feeds only the second
  // Any bounce back to the settled level restarts the count
  always_comb begin
    btnSync_d = {btnSync_q[0], wakeButton_n};
    btnDeb_d = btnDeb_q;
    debCnt_d = 16'h0000;
    if (btnSync_q[1] != btnDeb_q) begin
      debCnt_d = debCnt_q + 16'h0001;
      if (debCnt_q >= `DEBOUNCE_CYC - 16'h0001) begin
        btnDeb_d = btnSync_q[1];
        debCnt_d = 16'h0000;
      end
    end
  end

  // Battery switch sequencer: storage exit and full power reset
  // Press time counts only once the debounced level is low
  always_comb begin
    sw_d = sw_q;
    swOn_d = swOn_q;
    offCnt_d = offCnt_q;
    pressCnt_d = btnDeb_q ? 32'h0 : pressCnt_q + 32'h1;
    case (sw_q)
      charger_ctrl_pkg::SW_ON: begin
        if (control_q[`CTL_STORAGE_ENTER]) begin
          sw_d = charger_ctrl_pkg::SW_STORAGE;
          swOn_d = 1'b0;
        end else if (!inputSupplyPresent && pressCnt_q >= RESET_PRESS_CYC) begin
          sw_d = charger_ctrl_pkg::SW_RESET_OFF;
          swOn_d = 1'b0;
          offCnt_d = 32'h0;
        end
      end
      charger_ctrl_pkg::SW_STORAGE: begin
        if (pressCnt_q >= STORAGE_EXIT_CYC) begin
          sw_d = charger_ctrl_pkg::SW_WAIT_RELEASE;
          swOn_d = 1'b1;
        end
      end
      charger_ctrl_pkg::SW_RESET_OFF: begin
        offCnt_d = offCnt_q + 32'h1;
        if (offCnt_q >= SWITCH_OFF_CYC - 1) begin
          sw_d = charger_ctrl_pkg::SW_WAIT_RELEASE;
          swOn_d = 1'b1;
        end
      end
      charger_ctrl_pkg::SW_WAIT_RELEASE: begin
        // A held button must not retrigger a second reset
        if (btnDeb_q) begin
          sw_d = charger_ctrl_pkg::SW_ON;
        end
      end
      default: begin
        sw_d = charger_ctrl_pkg::SW_ON;
        swOn_d = 1'b1;
      end
    endcase
  end

  // Register file, events and APB answer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      control_q <= `CTL_RESET;
      eventEn_q <= '0;
      event_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      faultSeen_q <= 1'b0;
    end else begin
      control_q <= control_d;
      eventEn_q <= eventEn_d;
      event_q <= event_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      faultSeen_q <= faultSeen_d;
    end
  end

  // Gated controls, alert timer and indicator
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      boost_q <= 1'b0;
      charge_q <= 1'b0;
      cap_q <= 8'h00;
      status_q <= '0;
      alertCnt_q <= 32'h0;
      alertLow_q <= 1'b0;
      blinkCnt_q <= 32'h0;
      blink_q <= 1'b0;
      indLow_q <= 1'b0;
    end else begin
      boost_q <= boost_d;
      charge_q <= charge_d;
      cap_q <= cap_d;
      status_q <= status_d;
      alertCnt_q <= alertCnt_d;
      alertLow_q <= alertLow_d;
      blinkCnt_q <= blinkCnt_d;
      blink_q <= blink_d;
      indLow_q <= indLow_d;
    end
  end

  // Button and battery switch; synchroniser and debounce reset to the
  // released level so that leaving reset never looks like a press
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      btnSync_q <= 2'b11;
      btnDeb_q <= 1'b1;
      debCnt_q <= 16'h0000;
      pressCnt_q <= 32'h0;
      offCnt_q <= 32'h0;
      sw_q <= charger_ctrl_pkg::SW_ON;
      swOn_q <= 1'b1;
    end else begin
      btnSync_q <= btnSync_d;
      btnDeb_q <= btnDeb_d;
      debCnt_q <= debCnt_d;
      pressCnt_q <= pressCnt_d;
      offCnt_q <= offCnt_d;
      sw_q <= sw_d;
      swOn_q <= swOn_d;
    end
  end

  // Open-drain pins never drive high: output data is tied low
  assign alertOut = 1'b0;
  assign alertOe = alertLow_q;
  assign chargeIndOut = 1'b0;
  assign chargeIndOe = indLow_q;

  // APB answer straight from its registers
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Controls and switch state, each from its own flip-flop
  assign irq = irq_q;
  assign boostEnable = boost_q;
  assign chargeEnable = charge_q;
  assign effectiveCurrentCap = cap_q;
  assign batterySwitchOn = swOn_q;

endmodule : charger_control_pin_logic
`default_nettype wire

// ==== tb/charger_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_host_model (
  input wire logic alertOut,
  input wire logic alertOe,
  input wire logic chargeIndOut,
  input wire logic chargeIndOe,
  output logic alertWire,
  output logic chargeIndWire
);
  // Board pull-ups give the idle level; the pins can only sink
  assign alertWire = alertOe ? alertOut : 1'b1;
  assign chargeIndWire = chargeIndOe ? chargeIndOut : 1'b1;
endmodule : charger_host_model
`default_nettype wire

// ==== tb/charger_control_pin_logic_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_control_pin_logic_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic boostRequestPin,
  input wire logic chargeEnablePin_n,
  input wire logic inputSupplyPresent,
  input wire logic thermistorWindowOk,
  input wire logic wakeButton_n,
  input wire logic alertOut,
  input wire logic alertOe,
  input wire logic chargeIndOut,
  input wire logic chargeIndOe,
  input wire logic boostEnable,
  input wire logic chargeEnable,
  input wire logic batterySwitchOn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] lowRun_q, lowRun_d;
  // Pulse length so far; a retrigger may only lengthen it
  always_comb lowRun_d = alertOe ? lowRun_q + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk) lowRun_q <= resetn ? lowRun_d : 16'h0000;
  chk_alert_sink: assert property (!alertOut) else $error("alert driven high");
  chk_alert_width: assert property ($fell(alertOe) |-> lowRun_q >= 16'h2800)
    else $error("alert pulse short");
  chk_alert_cause: assert property ($changed(thermistorWindowOk) |-> ##[1:3] alertOe)
    else $error("no alert on status change");
  chk_boost_gate: assert property (boostEnable |-> $past(boostRequestPin) && !$past(inputSupplyPresent))
    else $error("boost without its conditions");
  chk_charge_gate: assert property (chargeEnable |-> !$past(chargeEnablePin_n) && $past(thermistorWindowOk))
    else $error("charging without its conditions");
  chk_ind_follow: assert property ($rose(chargeEnable) |-> ##[0:2] chargeIndOe)
    else $error("indicator not low while charging");
  chk_ind_sink: assert property (!chargeIndOut) else $error("indicator driven high");
  chk_switch_off: assert property ($fell(batterySwitchOn) |-> !batterySwitchOn [*8])
    else $error("switch off too short");
  chk_switch_wake: assert property ($rose(batterySwitchOn) |-> !$past(wakeButton_n))
    else $error("switch on without press");
  cover property ($fell(alertOe));
  cover property ($rose(batterySwitchOn));
  cover property ($rose(boostEnable));
endmodule : charger_control_pin_logic_checker
bind charger_control_pin_logic charger_control_pin_logic_checker chk_inst (.ref_clk(ref_clk), .resetn(resetn),
  .boostRequestPin(boostRequestPin), .chargeEnablePin_n(chargeEnablePin_n), .inputSupplyPresent(inputSupplyPresent),
  .thermistorWindowOk(thermistorWindowOk), .wakeButton_n(wakeButton_n), .alertOut(alertOut), .alertOe(alertOe),
  .chargeIndOut(chargeIndOut), .chargeIndOe(chargeIndOe), .boostEnable(boostEnable), .chargeEnable(chargeEnable),
  .batterySwitchOn(batterySwitchOn));
`default_nettype wire

// ==== tb/charger_control_pin_logic_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "charger_ctrl_defs.svh"
module charger_control_pin_logic_bench;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, alertOut, alertOe, chargeIndOut, chargeIndOe, irq, last;
  logic boostRequestPin = 1'b0, chargeEnablePin_n = 1'b1, inputSupplyPresent = 1'b1;
  logic thermistorWindowOk = 1'b1, wakeButton_n = 1'b1, boostEnable, chargeEnable, batterySwitchOn;
  logic [7:0] currentCapPin = 8'h00, effectiveCurrentCap;
  logic alertWire, chargeIndWire;
  int badCount = 0, checkCount = 0, n, t;
  charger_control_pin_logic #(.STORAGE_EXIT_CYC(400), .RESET_PRESS_CYC(800), .SWITCH_OFF_CYC(200),
    .BLINK_HALF_CYC(100)) charger_control_pin_logic_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boostRequestPin(boostRequestPin),
    .chargeEnablePin_n(chargeEnablePin_n), .inputSupplyPresent(inputSupplyPresent), .currentCapPin(currentCapPin),
    .thermistorWindowOk(thermistorWindowOk), .wakeButton_n(wakeButton_n), .alertOut(alertOut), .alertOe(alertOe),
    .chargeIndOut(chargeIndOut), .chargeIndOe(chargeIndOe), .boostEnable(boostEnable), .chargeEnable(chargeEnable),
    .effectiveCurrentCap(effectiveCurrentCap), .batterySwitchOn(batterySwitchOn), .irq(irq));
  charger_host_model charger_host_model_inst (.alertOut(alertOut), .alertOe(alertOe), .chargeIndOut(chargeIndOut),
    .chargeIndOe(chargeIndOe), .alertWire(alertWire), .chargeIndWire(chargeIndWire));
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : tick
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1); // Only the watchdog ends a wait
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic testRegs;
    apb(1'b0, `REG_CONTROL, 32'h0);
    check(rd, `CTL_RESET);
    apb(1'b0, 12'h0f0, 32'h0);
    check({rd[31:1], err}, 32'h1);
    $display("regs done");
  endtask : testRegs
  task automatic testBoost;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `REG_CONTROL, {31'h0, i[0]});
      boostRequestPin <= i[1];
      inputSupplyPresent <= i[2];
      tick(3);
      check(32'(boostEnable), 32'(i == 3));
    end
    $display("boost done");
  endtask : testBoost
  task automatic testCharge;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `REG_CONTROL, {30'h0, i[0], 1'b0});
      chargeEnablePin_n <= i[1];
      tick(3);
      check(32'(chargeEnable), 32'(i == 1));
      check(32'(chargeIndWire), 32'(i != 1));
    end
    chargeEnablePin_n <= 1'b0;
    apb(1'b1, `REG_EVENT_CLEAR, 32'h7);
    apb(1'b1, `REG_EVENT_ENABLE, 32'h2);
    // Let earlier pulses finish so the next one is measured alone
    n = 0;
    while (alertWire !== 1'b1 && n++ < 12000) tick(1);
    thermistorWindowOk <= 1'b0;
    n = 0;
    t = 0;
    last = chargeIndWire;
    repeat (10400) begin
      @(posedge ref_clk);
      n += (alertWire === 1'b0);
      t += (chargeIndWire !== last);
      last = chargeIndWire;
    end
    check(n, 10240);
    check(32'(t inside {[103:105]}), 1);
    check(32'(chargeEnable), 0);
    check(32'(irq), 1);
    apb(1'b0, `REG_EVENT, 32'h0);
    check(rd & 32'h2, 32'h2);
    apb(1'b1, `REG_EVENT_ENABLE, 32'h0);
    tick(2);
    check(32'(irq), 0);
    apb(1'b1, `REG_EVENT_ENABLE, 32'h2);
    tick(2);
    check(32'(irq), 1);
    thermistorWindowOk <= 1'b1;
    tick(3);
    check(32'(chargeEnable), 1);
    apb(1'b1, `REG_EVENT_CLEAR, 32'h7);
    tick(2);
    check(32'(irq), 0);
    $display("charge done");
  endtask : testCharge
  task automatic testCap;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `REG_CONTROL, {16'h0, 8'h40, 5'h0, i < 2, 2'h0});
      currentCapPin <= (i == 1) ? 8'h60 : 8'h20;
      tick(3);
      check(32'(effectiveCurrentCap), (i == 0) ? 32'h20 : 32'h40);
    end
    $display("cap done");
  endtask : testCap
  task automatic testSwitch;
    inputSupplyPresent <= 1'b1;
    wakeButton_n <= 1'b0;
    tick(1200);
    check(32'(batterySwitchOn), 1);
    wakeButton_n <= 1'b1;
    tick(300);
    inputSupplyPresent <= 1'b0;
    wakeButton_n <= 1'b0;
    n = 0;
    while (batterySwitchOn === 1'b1 && n++ < 2000) tick(1);
    check(32'(n inside {[1056:1064]}), 1);
    n = 0;
    while (batterySwitchOn === 1'b0 && n++ < 1000) tick(1);
    check(32'(n inside {[199:203]}), 1);
    wakeButton_n <= 1'b1;
    tick(300);
    apb(1'b1, `REG_CONTROL, 32'h8);
    tick(3);
    check(32'(batterySwitchOn), 0);
    wakeButton_n <= 1'b0;
    tick(556);
    check(32'(batterySwitchOn), 0);
    tick(200);
    check(32'(batterySwitchOn), 1);
    wakeButton_n <= 1'b1;
    $display("switch done");
  endtask : testSwitch
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrapUp
  // Main sequence after a 12-cycle reset
  initial begin
    tick(12);
    resetn <= 1'b1;
    tick(2);
    testRegs;
    testBoost;
    testCharge;
    testCap;
    testSwitch;
    wrapUp;
  end
  // Watchdog: tests need about 25000 cycles
  initial begin
    tick(90000);
    badCount++;
    wrapUp;
  end
endmodule : charger_control_pin_logic_bench
`default_nettype wire
